// ---- include/fhp_defs.svh ----
// Offsets, field positions, reset values and timing counts of the flash pulse control
`ifndef FHP_DEFS_SVH
`define FHP_DEFS_SVH
`define FHP_OFF_BASE_HIGH 12'h008
`define FHP_OFF_BASE_LOW 12'h00A
`define FHP_OFF_CTL_ONE 12'h00C
`define FHP_OFF_CTL_TWO 12'h00E
`define FHP_OFF_MODULE 12'h010
`define FHP_OFF_TEST 12'h014
`define FHP_ARRAY_LIMIT 32'h0004_0000
`define FHP_SHADOW_BASE 4'h8
`define FHP_SHADOW_CTL 4'hC
`define FHP_BIT_HVS 15
`define FHP_BIT_PE_ENABLE_MONITOR 5
`define FHP_BIT_BLOCK_ZERO_ENABLE_MONITOR 4
`define FHP_BIT_ERASE 2
`define FHP_BIT_SES 1
`define FHP_BIT_EHV 0
`define FHP_BIT_STOP 1
`define FHP_BIT_LOCK 0
`define FHP_EXP_BASE 5'h05
`define FHP_EXP_ERASE 5'h0A
`define FHP_RECOVERY_SCALED 8'h30
`define FHP_RECOVERY_RAW 8'h80
`define FHP_BASE_HIGH_MASK 16'h00FF
`define FHP_BASE_LOW_MASK 16'hF000
`define FHP_CTL_ONE_MASK 16'h3B7F
`define FHP_CTL_TWO_RESET 16'h0000
`define FHP_SCALED_MAX_NS 125
`endif

// ---- include/fhp_pkg.sv ----
// Types of the flash pulse control
package fhp_pkg;
  typedef enum logic [1:0] {
    FHP_IDLE,
    FHP_PULSE,
    FHP_RECOVER
  } fhp_state_e;
  typedef struct packed {
    logic [2:0] range;
    logic [1:0] exponent;
    logic [6:0] multiple;
  } fhp_timing_s;
endpackage : fhp_pkg

// ---- hw/fhp_pulse_control.sv ----
// Flash high-voltage pulse control with APB registers and shadow reset load
// How it works
// - Base address is high register bits 7:0 as bits 23:16 joined with low register bits 15:12.
// - Base high field reloads from shadow word 0x000008 after reset; low field resets to 0.
// - Base writes need lock bit 1 and stop state, else dropped.
// - Read-only status bit 15 is 1 during pulse or recovery.
// - Array accesses wait while status is 1.
// - Status 1 freezes sequence start and blocks clock stop.
// - Enable bit starts pulse; clearing it or timer expiry ends it.
// - Recovery is 48 scaled clocks, or 128 clocks with range zero.
// - Status reads 0 once reset completes.
// - Range field 13:11 frozen while sequence start is 1.
// - Scaled clock period is system period times range factor.
// - Exponent is 5 plus field 9:8 plus 10 when erasing; frozen.
// - Multiplier is 1 plus field 6:0; frozen during sequence.
// - Amplitude select nonzero lifts the timing field freeze.
// - Timing fields reload from shadow location 0xC after reset.
// - Block select field 15:8 picks blocks; frozen during sequence.
// - Enable monitor bit 5 captured at pulse start; 0 blocks high voltage.
// - Both enable inputs change only after two equal samples.
// - Block zero monitor bit 4 captured at start gates block 0.
// - Enable bit sets only after sequence start and an interlock write.
// - Pulse width is period times factor times 2^N times multiplier.
// - Range zero: timer never ends the pulse.
//
// Added by the designer: register access over APB and the register offsets.
`timescale 1ns/10ps
`include "fhp_defs.svh"
module fhp_pulse_control
  import fhp_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic [3:0] shadow_addr,
  input wire logic [15:0] shadow_data,
  input wire logic pe_enable_input,
  input wire logic block_zero_enable_input,
  output logic [31:0] array_base_pair,
  output logic pump_clock_enable,
  output logic hv_apply,
  output logic [7:0] hv_block_enable,
  output logic hv_erase,
  output logic clock_stop_ok,
  output logic interlock_write
);

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  // Scaling in half cycles, so 3/2 stays integral
  function automatic logic [2:0] half_scale(input logic [2:0] range);
    case (range)
      3'h1: half_scale = 3'h2;
      3'h2: half_scale = 3'h3;
      3'h3: half_scale = 3'h4;
      3'h4: half_scale = 3'h6;
      default: half_scale = 3'h2;
    endcase
  endfunction : half_scale

  function automatic logic in_array(input logic [31:0] a, input logic [31:0] base);
    in_array = (a >= base) && (a < base + `FHP_ARRAY_LIMIT);
  endfunction : in_array

  ////////////////////////////////////////////////////////////////////////////
  // State

  fhp_state_e state_reg, state_next;
  fhp_timing_s timing_reg, timing_next;
  logic [15:0] base_high_reg, base_high_next;
  logic [15:0] base_low_reg, base_low_next;
  logic [7:0] block_reg, block_next;
  logic erase_reg, erase_next;
  logic ses_reg, ses_next;
  logic ehv_reg, ehv_next;
  logic pe_enable_monitor_reg, pe_enable_monitor_next;
  logic block_zero_enable_monitor_reg, block_zero_enable_monitor_next;
  logic lock_reg, lock_next;
  logic stop_reg, stop_next;
  logic [2:0] program_amplitude_select_reg, program_amplitude_select_next;
  logic armed_reg, armed_next;
  logic [1:0] load_reg, load_next;
  logic [2:0] half_reg, half_next;
  logic [17:0] pow_reg, pow_next;
  logic [6:0] mult_reg, mult_next;
  logic [7:0] rec_reg, rec_next;
  logic [31:0] prdata_next;
  logic pready_next, pslverr_next;
  logic pump_next, apply_next, iw_next;
  logic pe_s1_reg, pe_s2_reg, pe_last_reg, pe_filt_reg, pe_filt_next;
  logic b0_s1_reg, b0_s2_reg, b0_last_reg, b0_filt_reg, b0_filt_next;

  logic high_voltage_status;
  logic loaded;
  logic timing_open;
  logic access, wr;
  logic [11:0] off;
  logic is_reg, is_arr;
  logic [4:0] expo;
  logic tick;
  logic [15:0] rdv;

  ////////////////////////////////////////////////////////////////////////////
  // Combinational

  always_comb begin
    high_voltage_status = (state_reg != FHP_IDLE);
    loaded = (load_reg == 2'h2);
    timing_open = !ses_reg || (program_amplitude_select_reg != 3'h0);
    access = psel && penable && !pready;
    off = paddr[11:0];
    is_reg = (paddr[31:12] == 20'h0_0000);
    is_arr = !is_reg && in_array(paddr, array_base_pair);
    wr = access && pwrite;
    expo = `FHP_EXP_BASE + {3'h0, timing_reg.exponent}
         + (erase_reg ? `FHP_EXP_ERASE : 5'h00);
    tick = (half_reg <= 3'h2);
    pe_filt_next = (pe_s2_reg == pe_last_reg) ? pe_s2_reg : pe_filt_reg;
    b0_filt_next = (b0_s2_reg == b0_last_reg) ? b0_s2_reg : b0_filt_reg;
    state_next = state_reg;
    timing_next = timing_reg;
    base_high_next = base_high_reg;
    base_low_next = base_low_reg;
    block_next = block_reg;
    erase_next = erase_reg;
    ses_next = ses_reg;
    ehv_next = ehv_reg;
    pe_enable_monitor_next = pe_enable_monitor_reg;
    block_zero_enable_monitor_next = block_zero_enable_monitor_reg;
    lock_next = lock_reg;
    stop_next = stop_reg;
    program_amplitude_select_next = program_amplitude_select_reg;
    armed_next = armed_reg;
    load_next = load_reg;
    half_next = half_reg;
    pow_next = pow_reg;
    mult_next = mult_reg;
    rec_next = rec_reg;
    prdata_next = 32'h0000_0000;
    pready_next = 1'b0;
    pslverr_next = 1'b0;
    iw_next = 1'b0;
    pump_next = 1'b0;
    rdv = 16'h0000;
    // Shadow load: base address then timing, one word each
    case (load_reg)
      2'h0: begin
        base_high_next = shadow_data & `FHP_BASE_HIGH_MASK;
        load_next = 2'h1;
      end
      2'h1: begin
        timing_next = fhp_timing_s'({shadow_data[13:11], shadow_data[9:8],
                                     shadow_data[6:0]});
        load_next = 2'h2;
      end
      default: load_next = 2'h2;
    endcase
    // Bus
    if (access && loaded) begin
      if (is_reg) begin
        pready_next = 1'b1;
        case (off)
          `FHP_OFF_BASE_HIGH: rdv = base_high_reg;
          `FHP_OFF_BASE_LOW: rdv = base_low_reg;
          `FHP_OFF_CTL_ONE: rdv = {high_voltage_status, 1'b0, timing_reg.range, 1'b0, timing_reg.exponent,
                                   1'b0, timing_reg.multiple};
          `FHP_OFF_CTL_TWO: rdv = {block_reg, 2'h0, pe_enable_monitor_reg, block_zero_enable_monitor_reg, 1'b0, erase_reg,
                                   ses_reg, ehv_reg};
          `FHP_OFF_MODULE: rdv = {14'h0000, stop_reg, lock_reg};
          `FHP_OFF_TEST: rdv = {5'h00, program_amplitude_select_reg, 8'h00};
          default: pslverr_next = 1'b1;
        endcase
        prdata_next = {16'h0000, rdv};
        if (wr) begin
          case (off)
            `FHP_OFF_BASE_HIGH: if (lock_reg && stop_reg)
              base_high_next = pwdata[15:0] & `FHP_BASE_HIGH_MASK;
            `FHP_OFF_BASE_LOW: if (lock_reg && stop_reg)
              base_low_next = pwdata[15:0] & `FHP_BASE_LOW_MASK;
            `FHP_OFF_CTL_ONE: if (timing_open) begin
              timing_next.range = pwdata[13:11];
              timing_next.exponent = pwdata[9:8];
              timing_next.multiple = pwdata[6:0];
            end
            `FHP_OFF_CTL_TWO: begin
              if (!ses_reg) begin
                block_next = pwdata[15:8];
                erase_next = pwdata[`FHP_BIT_ERASE];
              end
              if (!high_voltage_status && !ehv_reg) begin
                ses_next = pwdata[`FHP_BIT_SES];
                if (!pwdata[`FHP_BIT_SES])
                  armed_next = 1'b0;
              end
              if (pwdata[`FHP_BIT_EHV] && !ehv_reg && !high_voltage_status && ses_reg && armed_reg
                  && !stop_reg) begin
                ehv_next = 1'b1;
                pe_enable_monitor_next = pe_filt_reg;
                block_zero_enable_monitor_next = b0_filt_reg;
              end else if (!pwdata[`FHP_BIT_EHV]) begin
                ehv_next = 1'b0;
              end
            end
            `FHP_OFF_MODULE: begin
              stop_next = pwdata[`FHP_BIT_STOP] || (!high_voltage_status ? 1'b0 : stop_reg);
              lock_next = lock_reg & pwdata[`FHP_BIT_LOCK];
              if (pwdata[`FHP_BIT_STOP])
                ehv_next = 1'b0;
            end
            `FHP_OFF_TEST: if (!high_voltage_status)
              program_amplitude_select_next = pwdata[10:8];
            default: ;
          endcase
        end
      end else if (is_arr) begin
        if (!high_voltage_status && !ehv_reg) begin
          pready_next = 1'b1;
          if (wr && ses_reg) begin
            armed_next = 1'b1;
            iw_next = 1'b1;
          end
        end
      end else begin
        pready_next = 1'b1;
        pslverr_next = 1'b1;
      end
    end
    // Pulse timer
    if (high_voltage_status)
      half_next = 3'(half_reg - 3'h2 + (tick ? half_scale(timing_reg.range) : 3'h0));
    case (state_reg)
      FHP_IDLE: begin
        half_next = half_scale(timing_reg.range);
        pow_next = 18'h0_0000;
        mult_next = 7'h00;
        if (ehv_next && !ehv_reg)
          state_next = FHP_PULSE;
      end
      FHP_PULSE: begin
        pump_next = tick;
        if (tick && timing_reg.range != 3'h0) begin
          pow_next = 18'(pow_reg + 18'h0_0001);
          if (pow_reg == 18'((19'h0_0001 << expo) - 19'h0_0001)) begin
            pow_next = 18'h0_0000;
            mult_next = 7'(mult_reg + 7'h01);
            if (mult_reg == timing_reg.multiple)
              ehv_next = 1'b0;
          end
        end
        if (!ehv_next) begin
          state_next = FHP_RECOVER;
          rec_next = (timing_reg.range == 3'h0) ? `FHP_RECOVERY_RAW : `FHP_RECOVERY_SCALED;
        end
      end
      FHP_RECOVER: begin
        pump_next = tick;
        if (timing_reg.range == 3'h0 || tick)
          rec_next = 8'(rec_reg - 8'h01);
        if (rec_reg == 8'h01 && (timing_reg.range == 3'h0 || tick))
          state_next = FHP_IDLE;
      end
      default: state_next = FHP_IDLE;
    endcase
    apply_next = ehv_next && pe_enable_monitor_next;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= FHP_IDLE;
      timing_reg <= '0;
      base_high_reg <= 16'h0000;
      base_low_reg <= 16'h0000;
      block_reg <= 8'h00;
      erase_reg <= 1'b0;
      ses_reg <= 1'b0;
      ehv_reg <= 1'b0;
      pe_enable_monitor_reg <= 1'b0;
      block_zero_enable_monitor_reg <= 1'b0;
      lock_reg <= 1'b1;
      stop_reg <= 1'b0;
      program_amplitude_select_reg <= 3'h0;
      armed_reg <= 1'b0;
      load_reg <= 2'h0;
      half_reg <= 3'h2;
      pow_reg <= 18'h0_0000;
      mult_reg <= 7'h00;
      rec_reg <= 8'h00;
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
      shadow_addr <= `FHP_SHADOW_BASE;
      array_base_pair <= 32'h0000_0000;
      pump_clock_enable <= 1'b0;
      hv_apply <= 1'b0;
      hv_block_enable <= 8'h00;
      hv_erase <= 1'b0;
      clock_stop_ok <= 1'b0;
      interlock_write <= 1'b0;
      pe_s1_reg <= 1'b0;
      pe_s2_reg <= 1'b0;
      pe_last_reg <= 1'b0;
      pe_filt_reg <= 1'b0;
      b0_s1_reg <= 1'b0;
      b0_s2_reg <= 1'b0;
      b0_last_reg <= 1'b0;
      b0_filt_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      timing_reg <= timing_next;
      base_high_reg <= base_high_next;
      base_low_reg <= base_low_next;
      block_reg <= block_next;
      erase_reg <= erase_next;
      ses_reg <= ses_next;
      ehv_reg <= ehv_next;
      pe_enable_monitor_reg <= pe_enable_monitor_next;
      block_zero_enable_monitor_reg <= block_zero_enable_monitor_next;
      lock_reg <= lock_next;
      stop_reg <= stop_next;
      program_amplitude_select_reg <= program_amplitude_select_next;
      armed_reg <= armed_next;
      load_reg <= load_next;
      half_reg <= half_next;
      pow_reg <= pow_next;
      mult_reg <= mult_next;
      rec_reg <= rec_next;
      prdata <= prdata_next;
      pready <= pready_next;
      pslverr <= pslverr_next;
      shadow_addr <= (load_next == 2'h1) ? `FHP_SHADOW_CTL : `FHP_SHADOW_BASE;
      array_base_pair <= {base_high_next, base_low_next};
      pump_clock_enable <= pump_next;
      // Monitors gate the high voltage; block 0 needs its own monitor
      hv_apply <= apply_next;
      hv_block_enable <= apply_next ? {block_next[7:1], block_next[0] & block_zero_enable_monitor_next}
                                    : 8'h00;
      hv_erase <= erase_next;
      clock_stop_ok <= (state_next == FHP_IDLE);
      interlock_write <= iw_next;
      // Two-flop synchronisers, then equal-sample filter
      pe_s1_reg <= pe_enable_input;
      pe_s2_reg <= pe_s1_reg;
      pe_last_reg <= pe_s2_reg;
      pe_filt_reg <= pe_filt_next;
      b0_s1_reg <= block_zero_enable_input;
      b0_s2_reg <= b0_s1_reg;
      b0_last_reg <= b0_s2_reg;
      b0_filt_reg <= b0_filt_next;
    end
  end

endmodule : fhp_pulse_control

// ---- verification/fhp_shadow_model.sv ----
// Shadow row model answering the reset load of the pulse control
`timescale 1ns/10ps
module fhp_shadow_model #(
  parameter logic [15:0] BASE_WORD = 16'h0000,
  parameter logic [15:0] CTL_WORD = 16'h0a45
) (
  input wire logic pclk,
  input wire logic [3:0] shadow_addr,
  output logic [15:0] shadow_data
);
  ////////////////////////////////////////////////////////////////////////////////
  // Other words flip every cycle so a stray read never looks stable
  logic [15:0] junk_reg = 16'h5a5a;
  always_ff @(posedge pclk) begin
    junk_reg <= ~junk_reg;
  end
  always_comb begin
    case (shadow_addr)
      4'h8: shadow_data = BASE_WORD;
      4'hc: shadow_data = CTL_WORD;
      default: shadow_data = junk_reg;
    endcase
  end
endmodule : fhp_shadow_model

// ---- verification/fhp_pulse_control_props.sv ----
// Checker for the flash pulse control ports
`timescale 1ns/10ps
module fhp_pulse_control_chk (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic [31:0] paddr,
  input wire logic pready,
  input wire logic [3:0] shadow_addr,
  input wire logic [31:0] array_base_pair,
  input wire logic hv_apply,
  input wire logic pump_clock_enable,
  input wire logic clock_stop_ok,
  input wire logic interlock_write
);
  ////////////////////////////////////////////////////////////////////////////////
  // Edges since reset release, saturating
  logic [2:0] rcnt_reg;
  logic [2:0] rcnt_next;
  always_comb begin
    rcnt_next = (rcnt_reg == 3'h7) ? rcnt_reg : rcnt_reg + 3'h1;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rcnt_reg <= 3'h0;
    end else begin
      rcnt_reg <= rcnt_next;
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  ////////////////////////////////////////////////////////////////////////////////
  AST_SHADOW_BASE: assert property (rcnt_reg == 3'h0 |-> shadow_addr == 4'h8)
    else $error("shadow base word not read first");
  AST_SHADOW_CTL: assert property (rcnt_reg == 3'h1 |-> shadow_addr == 4'hc)
    else $error("shadow timing word not read second");
  AST_LOAD_FIRST: assert property (rcnt_reg < 3'h2 |-> !pready)
    else $error("bus answered during shadow load");
  AST_BASE_FORM: assert property (
      array_base_pair[11:0] == 12'h000 && array_base_pair[31:24] == 8'h00)
    else $error("base pair has bits outside its fields");
  AST_BASE_WRITE: assert property (
      rcnt_reg == 3'h7 && !$stable(array_base_pair) |-> pready || $past(pready))
    else $error("base pair moved without a bus write");
  AST_HOLD_ARRAY: assert property (
      psel && penable && !pready && paddr >= 32'h0000_1000 && !clock_stop_ok |=> !pready)
    else $error("array access answered while high voltage busy");
  AST_PUMP_IDLE: assert property (clock_stop_ok && $past(clock_stop_ok) |-> !pump_clock_enable)
    else $error("pump clock running while idle");
  AST_STOP_BLOCKED: assert property (hv_apply && $past(hv_apply) |-> !clock_stop_ok)
    else $error("clock stop allowed during pulse");
  AST_RECOVERY_MIN: assert property ($fell(hv_apply) |-> !clock_stop_ok [*8])
    else $error("recovery ended too soon");
  AST_RECOVERY_END: assert property ($fell(hv_apply) |-> ##[40:400] clock_stop_ok)
    else $error("recovery never ended");
  AST_PULSE_STATUS: assert property ($rose(hv_apply) |-> ##[0:2] !clock_stop_ok)
    else $error("pulse start did not raise status");
  AST_INTERLOCK: assert property (interlock_write |=> !interlock_write)
    else $error("interlock pulse longer than one cycle");
endmodule : fhp_pulse_control_chk
bind fhp_pulse_control fhp_pulse_control_chk i_chk (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .paddr(paddr), .pready(pready), .shadow_addr(shadow_addr),
  .array_base_pair(array_base_pair), .hv_apply(hv_apply),
  .pump_clock_enable(pump_clock_enable), .clock_stop_ok(clock_stop_ok),
  .interlock_write(interlock_write));

// ---- verification/tb_flash_hv_pulse_control.sv ----
// Testbench of the flash pulse control
`timescale 1ns/10ps
`include "fhp_defs.svh"
module tb_flash_hv_pulse_control;
  localparam logic [31:0] BH = {20'h0_0000, `FHP_OFF_BASE_HIGH};
  localparam logic [31:0] BL = {20'h0_0000, `FHP_OFF_BASE_LOW};
  localparam logic [31:0] C1 = {20'h0_0000, `FHP_OFF_CTL_ONE};
  localparam logic [31:0] C2 = {20'h0_0000, `FHP_OFF_CTL_TWO};
  localparam logic [31:0] MC = {20'h0_0000, `FHP_OFF_MODULE};
  localparam logic [31:0] TS = {20'h0_0000, `FHP_OFF_TEST};
  logic pclk = 1'b0;
  logic presetn, psel, penable, pwrite, pready, pslverr, pe_in, b0_in;
  logic [31:0] paddr, pwdata, prdata, array_base_pair, arr, q;
  logic [3:0] shadow_addr;
  logic [15:0] shadow_data, c1v;
  logic [7:0] hv_block_enable;
  logic pump_clock_enable, hv_apply, hv_erase, clock_stop_ok, interlock_write, e;
  int n_fail = 0;
  int total_checks = 0;
  int cyc = 0;
  int pw = 0;
  int rec = 0;
  fhp_pulse_control i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .shadow_addr(shadow_addr), .shadow_data(shadow_data),
    .pe_enable_input(pe_in), .block_zero_enable_input(b0_in),
    .array_base_pair(array_base_pair), .pump_clock_enable(pump_clock_enable),
    .hv_apply(hv_apply), .hv_block_enable(hv_block_enable), .hv_erase(hv_erase),
    .clock_stop_ok(clock_stop_ok), .interlock_write(interlock_write));
  fhp_shadow_model i_shadow (.pclk(pclk), .shadow_addr(shadow_addr), .shadow_data(shadow_data));
  initial begin
    forever #2 pclk = ~pclk;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // Pulse and recovery lengths, plus the hang limit
  always @(posedge pclk) begin
    cyc++;
    if (hv_apply === 1'b1) begin
      pw++;
      rec = 0;
    end else if (clock_stop_ok !== 1'b1) begin
      rec++;
    end
    if (cyc == 60000) begin
      n_fail++;
      end_sim();
    end
  end
  task end_sim;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : end_sim
  task chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task apb(input logic wr, input logic [31:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Array access may wait out a whole pulse; only the cycle limit ends a hang
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  // Scaling doubled, so the 3/2 range stays whole
  function int r2(input logic [2:0] r);
    case (r)
      3'h2: return 3;
      3'h3: return 4;
      3'h4: return 6;
      default: return 2;
    endcase
  endfunction : r2
  task run(input logic [15:0] c, input logic er);
    logic [15:0] c2;
    int x;
    c2 = {8'h03, 5'h00, er, 2'b10};
    apb(1'b1, C1, {16'h0000, c});
    apb(1'b1, C2, {16'h0000, c2});
    apb(1'b1, C2, {16'h0000, c2 | 16'h0001});
    apb(1'b0, C2, 32'h0000_0000);
    chk(q[0], 1'b0);
    apb(1'b1, arr, $urandom);
    apb(1'b1, C1, {16'h0000, ~c});
    apb(1'b0, C1, 32'h0000_0000);
    chk(q, {16'h0000, c & `FHP_CTL_ONE_MASK});
    pw = 0;
    apb(1'b1, C2, {16'h0000, c2 | 16'hfc01});
    apb(1'b0, C2, 32'h0000_0000);
    chk(q[13:0], {6'h03, 2'b00, pe_in, b0_in, 1'b0, er, 2'b11});
    chk(hv_apply, pe_in);
    chk(hv_erase, er);
    chk(hv_block_enable, pe_in ? {6'h00, 1'b1, b0_in} : 8'h00);
    apb(1'b0, C1, 32'h0000_0000);
    chk(q[15], 1'b1);
    if (er) begin
      repeat (60) @(posedge pclk);
      chk(hv_apply, pe_in);
      apb(1'b1, C2, {16'h0000, c2});
    end
    apb(1'b0, arr, 32'h0000_0000);
    chk(clock_stop_ok, 1'b1);
    x = (c[13:11] == 3'h0) ? 128 : 24 * r2(c[13:11]);
    if (pe_in) chk(rec >= x - 2 && rec <= x + 2, 1'b1);
    x = r2(c[13:11]) * (1 << (5 + c[9:8])) * (1 + c[6:0]);
    if (!er) chk(2 * pw >= x - 6 && 2 * pw <= x + 6, 1'b1);
    apb(1'b0, C2, 32'h0000_0000);
    chk(q[0], 1'b0);
    apb(1'b0, C1, 32'h0000_0000);
    chk(q[15], 1'b0);
    apb(1'b1, C2, 32'h0000_0000);
    $display("pulse test done");
  endtask : run
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    {presetn, psel, penable, pwrite, b0_in} = 5'h00;
    pe_in = 1'b1;
    paddr = 32'h0000_0000;
    pwdata = 32'h0000_0000;
    void'($urandom(80));
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, C2, 32'h0000_0000);
    chk(q, 32'h0000_0000);
    apb(1'b0, C1, 32'h0000_0000);
    chk(q, {16'h0000, 16'h0a45 & `FHP_CTL_ONE_MASK});
    apb(1'b0, MC, 32'h0000_0000);
    chk(q, 32'h0000_0001);
    apb(1'b0, 32'h0000_0004, 32'h0000_0000);
    chk(e, 1'b1);
    $display("reset test done");
    apb(1'b0, BH, 32'h0000_0000);
    arr = q;
    apb(1'b1, BH, ~arr);
    apb(1'b0, BH, 32'h0000_0000);
    chk(q, arr);
    arr = {8'h00, 8'($urandom), 4'($urandom), 12'h000};
    apb(1'b1, MC, 32'h0000_0003);
    apb(1'b1, BH, {16'h0000, arr[31:16]});
    apb(1'b1, BL, {16'h0000, arr[15:0]});
    apb(1'b1, MC, 32'h0000_0001);
    chk(array_base_pair, arr);
    arr = arr + 32'h0000_1000;
    $display("base test done");
    apb(1'b1, TS, 32'h0000_0100);
    apb(1'b1, C2, 32'h0000_0002);
    c1v = 16'($urandom);
    apb(1'b1, C1, {16'h0000, c1v});
    apb(1'b0, C1, 32'h0000_0000);
    chk(q, {16'h0000, c1v & `FHP_CTL_ONE_MASK});
    apb(1'b1, C2, 32'h0000_0000);
    apb(1'b1, TS, 32'h0000_0000);
    $display("amplitude test done");
    for (int i = 0; i < 3; i++) begin
      b0_in <= i[0];
      run({2'b00, 3'(1 + $urandom % 4), 1'b0, 2'($urandom), 1'b0, 7'(3 + $urandom % 8)}, 1'b0);
    end
    run({6'h00, 2'($urandom), 1'b0, 7'($urandom)}, 1'b1);
    pe_in <= 1'b0;
    b0_in <= 1'b1;
    @(posedge pclk);
    b0_in <= 1'b0;
    repeat (6) @(posedge pclk);
    run(16'h0003, 1'b1);
    end_sim();
  end
endmodule : tb_flash_hv_pulse_control
